//--- core/rlp_pkg.sv
// Shared constants, register map and carrier types of the LED PWM core.
// Assumes a 20 MHz reference clock and an APB master with 8-bit addresses.
package rlp_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int N_CH = 12;
    localparam int N_MOD = 4;
    localparam int N_GRP = 3;
    localparam int LVL_W = 8;
    localparam int DUTY_W = 12;
    localparam int CNT_W = 9;
    localparam int DITH_W = 3;
    localparam int ACC_W = 25;
    localparam int IDLE_W = 24;
    localparam int ADDR_W = 8;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int PWM_HZ = 29_000;
    localparam int TICK_HZ = PWM_HZ * (1 << CNT_W);
    localparam int IDLE_MS = 30;
    localparam int IDLE_CYC = (CLK_HZ / 1000) * IDLE_MS;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FOLLOW = 8'h04;
    localparam logic [7:0] OFS_GRP_COLOR = 8'h08;
    localparam logic [7:0] OFS_GRP_INT = 8'h0C;
    localparam logic [7:0] OFS_SOFT_RST = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MOD_INT = 8'h20;
    localparam logic [7:0] OFS_CHAN_COLOR = 8'h40;
    localparam int CTRL_CORE_ON = 0;
    localparam int CTRL_LOG = 1;
    localparam int CTRL_DITHER = 2;
    localparam int CTRL_SLEEP = 3;
    localparam int STAT_OT = 3;
    localparam int STAT_LOW = 4;
    localparam logic [7:0] LVL_FULL = 8'hFF;
    localparam logic [7:0] SOFT_RST_KEY = 8'hFF;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        MODE_SHUTDOWN, MODE_INIT, MODE_STANDBY, MODE_NORMAL, MODE_PSAVE, MODE_THERMAL
    } rlp_mode_t;

    typedef enum logic [1:0] {PH_LEAD, PH_CENTRE, PH_TRAIL} rlp_phase_t;

    typedef struct packed {
        logic core_on;
        logic log_curve_select;
        logic dither_on;
        logic idle_sleep_allow;
        logic [N_CH-1:0] group_follow;
        logic [N_GRP-1:0][LVL_W-1:0] grp_color;
        logic [LVL_W-1:0] grp_int;
        logic [N_MOD-1:0][LVL_W-1:0] module_intensity;
        logic [N_CH-1:0][LVL_W-1:0] channel_color_level;
    } rlp_cfg_t;

    localparam rlp_cfg_t CFG_RESET = '{
        core_on: 1'b0,
        log_curve_select: 1'b1,
        dither_on: 1'b1,
        idle_sleep_allow: 1'b1,
        group_follow: '0,
        grp_color: '0,
        grp_int: LVL_FULL,
        module_intensity: {N_MOD{LVL_FULL}},
        channel_color_level: '0
    };

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } rlp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rlp_apb_rsp_t;

endpackage

//--- core/rlp_pwm_chan.sv
// One sink channel: latches its duty at the period boundary and forms the pulse.
// Assumes a shared period counter and frame index from the core, same clock.
`timescale 1ns/1ns
module rlp_pwm_chan #(
    parameter rlp_pkg::rlp_phase_t PHASE = rlp_pkg::PH_LEAD
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Period timing
    input wire logic i_load,
    input wire logic [rlp_pkg::CNT_W-1:0] i_cnt,
    input wire logic [rlp_pkg::DITH_W-1:0] i_frame,
    // Duty and control
    input wire logic [rlp_pkg::DUTY_W-1:0] i_duty,
    input wire logic i_dither_on,
    input wire logic i_run,
    // Sink drive
    output logic o_sink
);
    localparam int W_W = rlp_pkg::CNT_W + 1;
    localparam logic [W_W-1:0] FULL = W_W'(1 << rlp_pkg::CNT_W);
    localparam logic [W_W-1:0] HALF = W_W'(1 << (rlp_pkg::CNT_W - 1));

    typedef struct packed {
        logic [rlp_pkg::DUTY_W-1:0] duty;
        logic out;
    } rlp_chan_st_t;

    rlp_chan_st_t st_reg;
    rlp_chan_st_t st_next;
    logic [W_W-1:0] width;
    logic [W_W-1:0] pos;
    logic [W_W-1:0] start;
    logic on;

    // ****************************************
    // Pulse shaping
    // ****************************************
    always_comb begin
        st_next = st_reg;
        // Extra LSB in duty[2:0] of every eight periods
        width = {1'b0, st_reg.duty[rlp_pkg::DUTY_W-1:rlp_pkg::DITH_W]}; // see R7
        if (i_dither_on && (i_frame < st_reg.duty[rlp_pkg::DITH_W-1:0])) begin // see R8 R9
            width = width + W_W'(1);
        end
        pos = {1'b0, i_cnt};
        start = HALF - (width >> 1);
        case (PHASE)
            rlp_pkg::PH_LEAD: on = pos < width; // see R11
            rlp_pkg::PH_CENTRE: on = (pos >= start) && (pos < start + width); // see R12
            rlp_pkg::PH_TRAIL: on = (pos + width) >= FULL; // see R13
            default: on = 1'b0;
        endcase
        st_next.out = i_run && on;
        // Only at the boundary, so a write never cuts a pulse short
        if (i_load) begin // see R26
            st_next.duty = i_duty;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sink = st_reg.out;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_sink_idle: assert property (!i_run |=> !o_sink) // see R21
        else $error("sink driven while not running");
    a_lead_start: assert property ((PHASE == rlp_pkg::PH_LEAD) && i_run && (width != '0) // see R11
        && (i_cnt == '0) |=> o_sink) else $error("leading pulse did not start at zero");
    a_trail_end: assert property ((PHASE == rlp_pkg::PH_TRAIL) && i_run && (width != '0) // see R13
        && (i_cnt == '1) |=> o_sink) else $error("trailing pulse not high at period end");
    a_duty_hold: assert property (!i_load |=> $stable(st_reg.duty)) // see R26
        else $error("duty changed away from the boundary");

endmodule

//--- core/rlp_core.sv
// LED PWM core: configuration over APB, duty mixing, 12 sink channels, modes.
// Assumes enable, lockout and over-temperature arrive asynchronously on pins.
//
// What this block does
// R1: Every sink output has its own 8-bit colour level.
// R2: Each triple of consecutive outputs shares one module intensity.
// R3: Module intensity offers 256 steps for all three outputs.
// R4: Intensity resets to FFh, meaning full factor; colour alone sets duty.
// R5: One global bit maps intensity through a log curve or linear.
// R6: Duty is colour level times scaled intensity.
// R7: 12-bit duty from 9-bit counter plus 3 dither bits.
// R8: Dither lengthens pulses one LSB in duty[2:0] of eight periods.
// R9: Dither enabled by default; off gives 9-bit accuracy.
// R10: Period set so each output switches near 29 kHz.
// R11: Outputs 0-2 and 9-11 fix the rising edge at period start.
// R12: Outputs 3-5 keep pulses centred, widening both ways.
// R13: Outputs 6-8 fix the falling edge at period end.
// R14: Per-channel follow bit, default 0; 1 selects group mode.
// R15: Group channels use group colour and group intensity only.
// R16: Group path uses the same multiply, curve, dither and PWM.
// R17: All outputs off over 30 ms with sleep allowed enters power-save.
// R18: Registers stay accessible in power-save; any access wakes to normal.
// R19: Enable rise, soft reset FFh or lockout enter init, resetting registers.
// R20: Core-on set moves the block to normal with outputs running.
// R21: Core-on clear gives standby: outputs off, registers kept.
// R22: Enable low forces shutdown from any state.
// R23: Over-temperature forces outputs off; clearing returns to normal.
// R24: Power-save qualification lies 20 to 40 ms, 30 ms nominal.
// R25: Channel index modulo three picks group colour A, B or C.
// R26: New duty loads into a channel only at a period boundary.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module rlp_core #(
    parameter int IDLE_CYC = rlp_pkg::IDLE_CYC
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Register bus
    input wire rlp_pkg::rlp_apb_req_t i_apb,
    output rlp_pkg::rlp_apb_rsp_t o_apb,
    // Device pins
    input wire logic i_enable,
    input wire logic i_supply_low_lockout,
    input wire logic i_over_temp,
    // Outputs
    output logic [rlp_pkg::N_CH-1:0] o_sink_output,
    output logic o_analog_on
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        rlp_pkg::rlp_cfg_t cfg;
        rlp_pkg::rlp_mode_t mode;
        logic [1:0] en_s;
        logic [1:0] low_s;
        logic [1:0] ot_s;
        logic en_prev;
        logic [rlp_pkg::ACC_W-1:0] acc;
        logic [rlp_pkg::CNT_W-1:0] cnt;
        logic [rlp_pkg::DITH_W-1:0] frame;
        logic [rlp_pkg::IDLE_W-1:0] idle;
        logic [31:0] rdata;
        logic rerr;
    } rlp_core_st_t;

    rlp_core_st_t st_reg;
    rlp_core_st_t st_next;

    logic [31:0] acc_sum;
    logic tick;
    logic wrap;
    logic setup;
    logic access;
    logic soft_rst;
    logic run;
    logic [rlp_pkg::N_CH-1:0][rlp_pkg::DUTY_W-1:0] duty;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic in_range(
        input logic [7:0] a,
        input logic [7:0] base,
        input int n
    );
        return (a >= base) && (a < base + 8'(4 * n)) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [3:0] reg_idx(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        return d[5:2];
    endfunction

    // Coarse power-of-two curve; FFh kept exact so full scale stays full
    function automatic logic [7:0] log_map(input logic [7:0] v);
        logic [12:0] t;
        t = 13'({1'b1, v[4:0]}) << v[7:5];
        if (v == 8'h00 || v == rlp_pkg::LVL_FULL) begin
            return v;
        end
        return t[12:5];
    endfunction

    function automatic logic [rlp_pkg::DUTY_W-1:0] duty_of(
        input logic [7:0] color,
        input logic [7:0] level,
        input logic use_log
    );
        logic [7:0] scaled;
        logic [8:0] factor;
        logic [16:0] prod;
        scaled = use_log ? log_map(level) : level; // see R5
        // FFh weighs as 256 so that colour alone sets duty
        factor = (scaled == rlp_pkg::LVL_FULL) ? 9'h100 : {1'b0, scaled}; // see R4 R3
        prod = 17'(color) * 17'(factor); // see R6
        return prod[15:4];
    endfunction

    function automatic logic [32:0] rd_mux(input rlp_core_st_t s, input logic [7:0] a);
        logic [31:0] d;
        logic err;
        d = 32'h0000_0000;
        err = 1'b0;
        if (in_range(a, rlp_pkg::OFS_MOD_INT, rlp_pkg::N_MOD)) begin
            d[7:0] = s.cfg.module_intensity[reg_idx(a, rlp_pkg::OFS_MOD_INT)];
        end else if (in_range(a, rlp_pkg::OFS_CHAN_COLOR, rlp_pkg::N_CH)) begin
            d[7:0] = s.cfg.channel_color_level[reg_idx(a, rlp_pkg::OFS_CHAN_COLOR)];
        end else begin
            case (a)
                rlp_pkg::OFS_CTRL: begin
                    d[rlp_pkg::CTRL_CORE_ON] = s.cfg.core_on;
                    d[rlp_pkg::CTRL_LOG] = s.cfg.log_curve_select;
                    d[rlp_pkg::CTRL_DITHER] = s.cfg.dither_on;
                    d[rlp_pkg::CTRL_SLEEP] = s.cfg.idle_sleep_allow;
                end
                rlp_pkg::OFS_FOLLOW: d[rlp_pkg::N_CH-1:0] = s.cfg.group_follow;
                rlp_pkg::OFS_GRP_COLOR: d[23:0] = s.cfg.grp_color;
                rlp_pkg::OFS_GRP_INT: d[7:0] = s.cfg.grp_int;
                rlp_pkg::OFS_SOFT_RST: d = 32'h0000_0000;
                rlp_pkg::OFS_STATUS: begin
                    d[2:0] = s.mode;
                    d[rlp_pkg::STAT_OT] = s.ot_s[1];
                    d[rlp_pkg::STAT_LOW] = s.low_s[1];
                end
                default: err = 1'b1;
            endcase
        end
        return {err, d};
    endfunction

    // ****************************************
    // Duty mixing and channels
    // ****************************************
    assign run = (st_reg.mode == rlp_pkg::MODE_NORMAL); // see R20 R21 R23

    genvar g;
    generate
        for (g = 0; g < rlp_pkg::N_CH; g++) begin : g_ch
            localparam rlp_pkg::rlp_phase_t PH = ((g / 3) % 3 == 0) ? rlp_pkg::PH_LEAD :
                ((g / 3) % 3 == 1) ? rlp_pkg::PH_CENTRE : rlp_pkg::PH_TRAIL;
            logic [7:0] color;
            logic [7:0] level;

            // Group colour by index modulo three, shared group intensity
            assign color = st_reg.cfg.group_follow[g] ? // see R14 R15 R25
                st_reg.cfg.grp_color[g % 3] : st_reg.cfg.channel_color_level[g]; // see R1
            assign level = st_reg.cfg.group_follow[g] ? // see R16
                st_reg.cfg.grp_int : st_reg.cfg.module_intensity[g / 3]; // see R2
            assign duty[g] = duty_of(color, level, st_reg.cfg.log_curve_select);

            rlp_pwm_chan #(
                .PHASE(PH)
            ) u_chan (
                .i_ref_clk(i_ref_clk),
                .i_rst_n(i_rst_n),
                .i_load(wrap),
                .i_cnt(st_reg.cnt),
                .i_frame(st_reg.frame),
                .i_duty(duty[g]),
                .i_dither_on(st_reg.cfg.dither_on),
                .i_run(run),
                .o_sink(o_sink_output[g])
            );
        end
    endgenerate

    // ****************************************
    // Next state
    // ****************************************
    // Fractional divider: the tick rate is 512 steps per 29 kHz period
    assign acc_sum = 32'(st_reg.acc) + 32'(rlp_pkg::TICK_HZ); // see R10
    assign tick = acc_sum >= 32'(rlp_pkg::CLK_HZ);
    assign wrap = tick && (st_reg.cnt == '1);
    assign setup = i_apb.psel && !i_apb.penable;
    assign access = i_apb.psel && i_apb.penable;
    assign soft_rst = access && i_apb.pwrite && (i_apb.paddr == rlp_pkg::OFS_SOFT_RST)
        && (i_apb.pwdata[7:0] == rlp_pkg::SOFT_RST_KEY);

    always_comb begin
        st_next = st_reg;
        // Pins pass two flops before any logic reads them
        st_next.en_s = {st_reg.en_s[0], i_enable};
        st_next.low_s = {st_reg.low_s[0], i_supply_low_lockout};
        st_next.ot_s = {st_reg.ot_s[0], i_over_temp};
        st_next.en_prev = st_reg.en_s[1];

        st_next.acc = tick ? rlp_pkg::ACC_W'(acc_sum - 32'(rlp_pkg::CLK_HZ))
            : rlp_pkg::ACC_W'(acc_sum);
        if (tick) begin
            st_next.cnt = st_reg.cnt + rlp_pkg::CNT_W'(1);
        end
        if (wrap) begin
            st_next.frame = st_reg.frame + rlp_pkg::DITH_W'(1); // see R8
        end

        // Read data captured in setup, presented in the access phase
        if (setup) begin
            {st_next.rerr, st_next.rdata} = rd_mux(st_reg, i_apb.paddr);
        end

        // Writes stay live in standby and power-save
        if (access && i_apb.pwrite && !st_reg.rerr) begin // see R18 R21
            if (in_range(i_apb.paddr, rlp_pkg::OFS_MOD_INT, rlp_pkg::N_MOD)) begin
                st_next.cfg.module_intensity[reg_idx(i_apb.paddr, rlp_pkg::OFS_MOD_INT)] =
                    i_apb.pwdata[7:0];
            end else if (in_range(i_apb.paddr, rlp_pkg::OFS_CHAN_COLOR, rlp_pkg::N_CH)) begin
                st_next.cfg.channel_color_level[reg_idx(i_apb.paddr, rlp_pkg::OFS_CHAN_COLOR)] =
                    i_apb.pwdata[7:0];
            end else begin
                case (i_apb.paddr)
                    rlp_pkg::OFS_CTRL: begin
                        st_next.cfg.core_on = i_apb.pwdata[rlp_pkg::CTRL_CORE_ON];
                        st_next.cfg.log_curve_select = i_apb.pwdata[rlp_pkg::CTRL_LOG];
                        st_next.cfg.dither_on = i_apb.pwdata[rlp_pkg::CTRL_DITHER];
                        st_next.cfg.idle_sleep_allow = i_apb.pwdata[rlp_pkg::CTRL_SLEEP];
                    end
                    rlp_pkg::OFS_FOLLOW: begin
                        st_next.cfg.group_follow = i_apb.pwdata[rlp_pkg::N_CH-1:0];
                    end
                    rlp_pkg::OFS_GRP_COLOR: st_next.cfg.grp_color = i_apb.pwdata[23:0];
                    rlp_pkg::OFS_GRP_INT: st_next.cfg.grp_int = i_apb.pwdata[7:0];
                    default: st_next.cfg = st_reg.cfg;
                endcase
            end
        end

        // ****************************************
        // Mode control
        // ****************************************
        if (!st_reg.en_s[1]) begin // see R22
            st_next.mode = rlp_pkg::MODE_SHUTDOWN;
        end else if ((st_reg.en_s[1] && !st_reg.en_prev) || st_reg.low_s[1] // see R19
            || soft_rst) begin
            st_next.mode = rlp_pkg::MODE_INIT;
        end else begin
            case (st_reg.mode)
                rlp_pkg::MODE_SHUTDOWN: st_next.mode = rlp_pkg::MODE_SHUTDOWN;
                rlp_pkg::MODE_INIT: begin
                    st_next.cfg = rlp_pkg::CFG_RESET; // see R19 R4 R9 R14 R17
                    st_next.mode = rlp_pkg::MODE_STANDBY;
                end
                rlp_pkg::MODE_STANDBY: begin
                    if (st_reg.cfg.core_on) begin // see R20
                        st_next.mode = rlp_pkg::MODE_NORMAL;
                    end
                end
                rlp_pkg::MODE_NORMAL: begin
                    if (st_reg.ot_s[1]) begin // see R23
                        st_next.mode = rlp_pkg::MODE_THERMAL;
                    end else if (!st_reg.cfg.core_on) begin // see R21
                        st_next.mode = rlp_pkg::MODE_STANDBY;
                    end else if ((|o_sink_output) || !st_reg.cfg.idle_sleep_allow) begin
                        st_next.idle = '0;
                    end else if (st_reg.idle == rlp_pkg::IDLE_W'(IDLE_CYC - 1)) begin // see R17 R24
                        st_next.mode = rlp_pkg::MODE_PSAVE;
                        st_next.idle = '0;
                    end else begin
                        st_next.idle = st_reg.idle + rlp_pkg::IDLE_W'(1);
                    end
                end
                rlp_pkg::MODE_PSAVE: begin
                    if (st_reg.ot_s[1]) begin
                        st_next.mode = rlp_pkg::MODE_THERMAL;
                    end else if (!st_reg.cfg.core_on) begin
                        st_next.mode = rlp_pkg::MODE_STANDBY;
                    end else if (access) begin // see R18
                        st_next.mode = rlp_pkg::MODE_NORMAL;
                    end
                end
                rlp_pkg::MODE_THERMAL: begin
                    if (!st_reg.ot_s[1]) begin // see R23
                        st_next.mode = rlp_pkg::MODE_NORMAL;
                    end
                end
                default: st_next.mode = rlp_pkg::MODE_SHUTDOWN;
            endcase
        end
        if (st_next.mode != rlp_pkg::MODE_NORMAL) begin
            st_next.idle = '0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '{
                cfg: rlp_pkg::CFG_RESET,
                mode: rlp_pkg::MODE_SHUTDOWN,
                default: '0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_apb.prdata = st_reg.rdata;
    assign o_apb.pready = access;
    assign o_apb.pslverr = access && st_reg.rerr;
    // Analog blocks run while driving and in thermal shutdown; power-save drops them
    assign o_analog_on = run || (st_reg.mode == rlp_pkg::MODE_THERMAL); // see R17

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_shutdown_low: assert property (!st_reg.en_s[1] |=> // see R22
        st_reg.mode == rlp_pkg::MODE_SHUTDOWN) else $error("enable low without shutdown");
    a_init_defaults: assert property ((st_reg.mode == rlp_pkg::MODE_INIT) // see R19
        && st_reg.en_s[1] && st_reg.en_prev && !st_reg.low_s[1] && !soft_rst
        |=> st_reg.cfg == rlp_pkg::CFG_RESET && st_reg.mode == rlp_pkg::MODE_STANDBY)
        else $error("init did not restore defaults");
    a_standby_dark: assert property ((st_reg.mode == rlp_pkg::MODE_STANDBY) // see R21
        |=> o_sink_output == '0) else $error("sink on in standby");
    a_thermal_dark: assert property ((st_reg.mode == rlp_pkg::MODE_THERMAL) // see R23
        |=> o_sink_output == '0) else $error("sink on in thermal shutdown");
    a_core_on_run: assert property ((st_reg.mode == rlp_pkg::MODE_STANDBY) // see R20
        && st_reg.cfg.core_on && st_reg.en_s[1] && st_reg.en_prev && !st_reg.low_s[1]
        && !soft_rst |=> st_reg.mode == rlp_pkg::MODE_NORMAL)
        else $error("core on did not reach normal");
    a_wake_access: assert property ((st_reg.mode == rlp_pkg::MODE_PSAVE) && access // see R18
        && st_reg.cfg.core_on && !st_reg.ot_s[1] && st_reg.en_s[1] && st_reg.en_prev
        && !st_reg.low_s[1] && !soft_rst |=> st_reg.mode == rlp_pkg::MODE_NORMAL)
        else $error("access did not wake power-save");
    a_sleep_entry: assert property ((st_reg.mode == rlp_pkg::MODE_PSAVE) // see R17 R24
        && ($past(st_reg.mode) == rlp_pkg::MODE_NORMAL) |->
        $past(st_reg.idle) == rlp_pkg::IDLE_W'(IDLE_CYC - 1)
        && $past(st_reg.cfg.idle_sleep_allow)) else $error("power-save entered early");
    a_period_gap: assert property (wrap |=> !wrap [*8]) // see R10
        else $error("period boundaries too close");

endmodule

//--- bench/rlp_led_model.sv
// LED strings on the sink outputs: counts conducting clocks per channel.
// Assumes sinks settle on the core clock; clear restarts every count.
`timescale 1ns/1ns
module rlp_led_model (
    // Clock and control
    input wire logic i_ref_clk,
    input wire logic i_clear,
    // Sinks and light
    input wire logic [11:0] i_sink,
    output logic [11:0][15:0] o_lit
);
    always @(posedge i_ref_clk) begin
        for (int k = 0; k < 12; k++) begin
            o_lit[k] <= i_clear ? 16'h0000 : o_lit[k] + 16'(i_sink[k]);
        end
    end
endmodule

//--- bench/tb_rlp_core.sv
// Bench for the LED PWM core: APB master, light counts, mode pins.
// Assumes IDLE_CYC shortened to 64; lockout pin driven by the bench.
`timescale 1ns/1ns
module tb_rlp_core;
    logic clk = 0, rst_n = 0, en = 1, ot = 0, low = 0, clr = 0, err, ana;
    logic [31:0] rd;
    logic [11:0] sink;
    logic [11:0][15:0] lit;
    int mismatches = 0, comparisons = 0;
    rlp_pkg::rlp_apb_req_t req = '0;
    rlp_pkg::rlp_apb_rsp_t rsp;
    rlp_core #(.IDLE_CYC(64)) dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_apb(req),
        .o_apb(rsp), .i_enable(en), .i_supply_low_lockout(low), .i_over_temp(ot),
        .o_sink_output(sink), .o_analog_on(ana));
    rlp_led_model leds (.i_ref_clk(clk), .i_clear(clr), .i_sink(sink), .o_lit(lit));
    initial begin
        forever #25 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask
    // Duty lands only at a period boundary, so settle first, then count 4 periods
    task near(input int c, input int exp);
        chk(32'(lit[c] > exp - 20 && lit[c] < exp + 20), 32'h1);
    endtask
    task measure();
        repeat (1400) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (2759) @(posedge clk);
    endtask
    task t_defaults();
        apb(0, rlp_pkg::OFS_CTRL, 0);
        chk(rd, 32'h0000000E);
        apb(0, rlp_pkg::OFS_MOD_INT, 0);
        chk(rd, 32'h000000FF);
        apb(0, 8'h80, 0);
        chk(err, 1);
        apb(0, rlp_pkg::OFS_STATUS, 0);
        chk(rd[2:0], 2);
    endtask
    task t_duty();
        // Sleep off: the dark first period would otherwise fall into power-save
        apb(1, rlp_pkg::OFS_CTRL, 32'h1);
        apb(1, rlp_pkg::OFS_CHAN_COLOR, 32'h80);
        apb(1, rlp_pkg::OFS_CHAN_COLOR + 8'h0C, 32'h80);
        apb(1, rlp_pkg::OFS_CHAN_COLOR + 8'h18, 32'hFF);
        apb(1, rlp_pkg::OFS_CHAN_COLOR + 8'h24, 32'hFF);
        apb(1, rlp_pkg::OFS_MOD_INT + 8'h08, 32'h80);
        measure();
        near(0, 1379);
        near(3, 1379);
        near(6, 1374);
        near(9, 2748);
        chk(lit[1], 0);
        apb(1, rlp_pkg::OFS_GRP_COLOR, 32'h8000);
        apb(1, rlp_pkg::OFS_FOLLOW, 32'h3);
        measure();
        chk(lit[0], 0);
        near(1, 1379);
    endtask
    task t_modes();
        ot <= 1'b1;
        repeat (10) @(posedge clk);
        chk(sink, 0);
        apb(0, rlp_pkg::OFS_STATUS, 0);
        chk(rd[2:0], 5);
        ot <= 1'b0;
        repeat (10) @(posedge clk);
        apb(0, rlp_pkg::OFS_STATUS, 0);
        chk(rd[2:0], 3);
        apb(1, rlp_pkg::OFS_CTRL, 32'h9);
        apb(1, rlp_pkg::OFS_GRP_COLOR, 0);
        apb(1, rlp_pkg::OFS_FOLLOW, 32'hFFF);
        repeat (1000) @(posedge clk);
        chk(ana, 0);
        apb(0, rlp_pkg::OFS_STATUS, 0);
        chk(rd[2:0], 4);
        repeat (2) @(posedge clk);
        chk(ana, 1);
        en <= 1'b0;
        repeat (10) @(posedge clk);
        chk(ana, 0);
        en <= 1'b1;
        repeat (10) @(posedge clk);
        apb(0, rlp_pkg::OFS_FOLLOW, 0);
        chk(rd, 0);
    endtask
    task t_resets();
        apb(1, rlp_pkg::OFS_FOLLOW, 32'h5);
        apb(0, rlp_pkg::OFS_FOLLOW, 0);
        chk(rd, 32'h5);
        apb(1, rlp_pkg::OFS_SOFT_RST, 32'hFF);
        apb(0, rlp_pkg::OFS_FOLLOW, 0);
        chk(rd, 0);
        apb(1, rlp_pkg::OFS_FOLLOW, 32'h5);
        low <= 1'b1;
        repeat (10) @(posedge clk);
        low <= 1'b0;
        repeat (10) @(posedge clk);
        apb(0, rlp_pkg::OFS_FOLLOW, 0);
        chk(rd, 0);
    endtask
    task wrap_up();
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #2000000;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        t_defaults();
        t_duty();
        t_modes();
        t_resets();
        wrap_up();
    end
endmodule
